// file: common/sems_pkg.sv
// constants and types shared by the two-wire serial memory slave
package sems_pkg;
  localparam int CLK_NS = 40;
  localparam int NOISE_NS = 100;
  // a pulse under NOISE_NS can cover this many samples less one, never all of them
  localparam int FILT_CYC = (NOISE_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int PROG_MS = 10;
  // longest time rounds down to whole clk cycles
  localparam int PROG_CYC = PROG_MS * 1000000 / CLK_NS;
  localparam int TMR_W = 20;
  localparam int AW = 9;
  localparam int MEM_BYTES = 512;
  localparam int ROW_BYTES = 8;
  localparam int MB_MAX = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // device type identifier, arbitrary value
  localparam logic [3:0] DEV_TYPE = 4'h5;
  localparam logic [8:0] PROT_BASE = 9'h100;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WORD = 3'h3,
    ST_WDATA = 3'h2,
    ST_BUSY = 3'h6,
    ST_READ = 3'h5
  } sems_state_t;
  typedef struct packed {
    logic cs_high;
    logic cs_low;
    logic protect;
    logic mode_multi;
  } sems_strap_t;
endpackage

// file: rtl/sems_slave.sv
// two-wire serial slave with 512 byte array, write buffer and programming timer
`timescale 1ns/100ps
module sems_slave #(
  parameter int PROG_CYCLES = sems_pkg::PROG_CYC, // programming time in clk cycles
  parameter logic [8:0] PROT_BASE = sems_pkg::PROT_BASE, // first protected byte
  parameter logic [3:0] DEV_TYPE = sems_pkg::DEV_TYPE // device type id, arbitrary
) (
  input logic clk, // system clock, 25 MHz
  input logic rstn, // async reset, active low
  input logic scl_clk, // serial clock from master
  input logic sda_i, // serial data line level
  output logic sda_o, // serial data out, always low
  output logic sda_oe, // high while pulling data line low
  input logic chip_select_bit_high, // hardwired chip select, upper
  input logic chip_select_bit_low, // hardwired chip select, lower
  input logic protect_key_input, // high protects upper region
  input logic wr_mode_sel, // high multibyte, low page mode
  output logic busy // programming cycle running
);
  localparam logic [1:0] FC_LAST = 2'(sems_pkg::FILT_CYC - 1);
  localparam logic [sems_pkg::TMR_W-1:0] T_ONE = sems_pkg::TMR_W'(PROG_CYCLES - 1);
  localparam logic [sems_pkg::TMR_W-1:0] T_TWO = sems_pkg::TMR_W'(2 * PROG_CYCLES - 1);

  // link domain: sample data on each serial clock rise
  logic lk_bit_q;
  logic lk_tog_q;
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      lk_bit_q <= 1'b1;
      lk_tog_q <= 1'b0;
    end else begin
      lk_bit_q <= sda_i;
      lk_tog_q <= ~lk_tog_q;
    end
  end

  // toggle crossing; the sampled bit stays stable for a whole clock period
  logic tg_s1_q;
  logic tg_s2_q;
  logic tg_s3_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  sems_pkg::sems_strap_t strap_s1_q;
  sems_pkg::sems_strap_t strap;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      strap_s1_q <= '0;
      strap <= '0;
    end else begin
      tg_s1_q <= lk_tog_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      pin_s1_q <= {scl_clk, sda_i};
      pin_s2_q <= pin_s1_q;
      strap_s1_q <= {chip_select_bit_high, chip_select_bit_low, protect_key_input, wr_mode_sel};
      strap <= strap_s1_q;
    end
  end

  // glitch filter: a level must hold FILT_CYC samples before it is taken
  logic [1:0] filt_q;
  logic [1:0] filt_old_q;
  logic [1:0][1:0] fc_q;
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        fc_q[i] <= 2'h0;
        filt_q[i] <= 1'b1;
        filt_old_q[i] <= 1'b1;
      end else begin
        filt_old_q[i] <= filt_q[i];
        if (pin_s2_q[i] == filt_q[i]) begin
          fc_q[i] <= 2'h0;
        end else if (fc_q[i] == FC_LAST) begin
          filt_q[i] <= pin_s2_q[i];
          fc_q[i] <= 2'h0;
        end else begin
          fc_q[i] <= fc_q[i] + 2'h1;
        end
      end
    end
  end

  sems_pkg::sems_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic oe_q;
  logic ackd_q;
  logic slot_q;
  logic mack_q;
  logic page_q;
  logic pm_q;
  logic [8:0] addr_q;
  logic [8:0] base_q;
  logic [7:0] wv_q;
  logic [3:0] wcnt_q;
  logic [sems_pkg::TMR_W-1:0] tmr_q;
  logic [7:0] mem_q [sems_pkg::MEM_BYTES];
  logic [7:0] wbuf_q [sems_pkg::ROW_BYTES];
  logic pend_q;

  wire scl_hi = filt_q[1] & filt_old_q[1];
  wire tog_ev = tg_s2_q ^ tg_s3_q;
  wire scl_rise = filt_q[1] & ~filt_old_q[1];
  // a short clock pulse toggles the link side but never raises the filtered clock
  // filtered rise, counted only with a pending or new link toggle
  wire rise = scl_rise & (pend_q | tog_ev);
  wire fall = filt_old_q[1] & ~filt_q[1];
  wire start = scl_hi & filt_old_q[0] & ~filt_q[0];
  wire stop = scl_hi & ~filt_old_q[0] & filt_q[0];
  wire busy_st = st_q == sems_pkg::ST_BUSY;
  wire byte_end = fall & (cnt_q == sems_pkg::BYTE_BITS);
  wire slot_end = fall & slot_q;
  wire mid_fall = fall & (cnt_q != 4'h0) & (cnt_q < sems_pkg::BYTE_BITS);
  wire match = (sr_q[7:4] == DEV_TYPE) & (sr_q[3:2] == {strap.cs_high, strap.cs_low});
  wire accept = pm_q | (wcnt_q < 4'(sems_pkg::MB_MAX));
  wire store = byte_end & (st_q == sems_pkg::ST_WDATA) & accept;
  wire commit = stop & (st_q == sems_pkg::ST_WDATA) & (|wv_q);
  wire [2:0] widx = pm_q ? addr_q[2:0] : wcnt_q[2:0];
  wire [8:0] addr_winc = pm_q ? {addr_q[8:3], addr_q[2:0] + 3'h1} : addr_q + 9'h1;
  wire [8:0] last = addr_q - 9'h1;
  wire span = ~pm_q & (base_q[8:3] != last[8:3]);
  wire [7:0] rd_byte = mem_q[addr_q];
  wire go_on = ackd_q | mack_q;

  // link rise waits here until the filtered clock confirms it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (pend_q | tog_ev) & ~scl_rise;
    end
  end

  // commit addresses and protection per buffer slot
  logic [7:0][8:0] ca;
  logic [7:0] prot;
  for (genvar i = 0; i < sems_pkg::ROW_BYTES; i++) begin : g_slot
    assign ca[i] = pm_q ? {base_q[8:3], 3'(i)} : 9'(base_q + 9'(i));
    assign prot[i] = strap.protect & (ca[i] >= PROT_BASE);
  end

  // array and write buffer hold no reset; contents are data, not control
  always_ff @(posedge clk) begin
    for (int i = 0; i < sems_pkg::ROW_BYTES; i++) begin
      if (commit && wv_q[i] && !prot[i]) begin
        mem_q[ca[i]] <= wbuf_q[i];
      end
    end
    if (store) begin
      wbuf_q[widx] <= sr_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= sems_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      ackd_q <= 1'b0;
      slot_q <= 1'b0;
      mack_q <= 1'b0;
      page_q <= 1'b0;
      pm_q <= 1'b0;
      addr_q <= 9'h000;
      base_q <= 9'h000;
      wv_q <= 8'h00;
      wcnt_q <= 4'h0;
      tmr_q <= '0;
    end else if (busy_st) begin
      if (tmr_q == '0) begin
        st_q <= sems_pkg::ST_IDLE;
      end else begin
        tmr_q <= tmr_q - 1'b1;
      end
    end else if (start) begin
      st_q <= sems_pkg::ST_DEV;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      ackd_q <= 1'b0;
      slot_q <= 1'b0;
      wv_q <= 8'h00;
      wcnt_q <= 4'h0;
    end else if (stop) begin
      oe_q <= 1'b0;
      slot_q <= 1'b0;
      st_q <= commit ? sems_pkg::ST_BUSY : sems_pkg::ST_IDLE;
      tmr_q <= span ? T_TWO : T_ONE;
    end else if (st_q != sems_pkg::ST_IDLE) begin
      if (rise) begin
        if (cnt_q < sems_pkg::BYTE_BITS) begin
          sr_q <= {sr_q[6:0], lk_bit_q};
          cnt_q <= cnt_q + 4'h1;
        end else begin
          cnt_q <= 4'h0;
          slot_q <= 1'b1;
          mack_q <= ~lk_bit_q;
        end
      end
      if (byte_end) begin
        case (st_q)
          sems_pkg::ST_DEV: begin
            oe_q <= match;
            ackd_q <= match;
            page_q <= sr_q[1];
            pm_q <= ~strap.mode_multi;
            if (!match) begin
              st_q <= sems_pkg::ST_IDLE;
            end else if (sr_q[0]) begin
              st_q <= sems_pkg::ST_READ;
            end else begin
              st_q <= sems_pkg::ST_WORD;
            end
          end
          sems_pkg::ST_WORD: begin
            addr_q <= {page_q, sr_q};
            base_q <= {page_q, sr_q};
            oe_q <= 1'b1;
            ackd_q <= 1'b1;
            st_q <= sems_pkg::ST_WDATA;
          end
          sems_pkg::ST_WDATA: begin
            oe_q <= accept;
            if (accept) begin
              wv_q[widx] <= 1'b1;
              wcnt_q <= wcnt_q + 4'h1;
              addr_q <= addr_winc;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end else if (slot_end) begin
        slot_q <= 1'b0;
        ackd_q <= 1'b0;
        oe_q <= 1'b0;
        if (st_q == sems_pkg::ST_READ) begin
          if (go_on) begin
            tx_q <= rd_byte;
            oe_q <= ~rd_byte[7];
            addr_q <= addr_q + 9'h1;
          end else begin
            st_q <= sems_pkg::ST_IDLE;
          end
        end
      end else if (mid_fall && st_q == sems_pkg::ST_READ) begin
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= ~tx_q[6];
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign busy = busy_st;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_ack_on_match: assert property (byte_end && st_q == sems_pkg::ST_DEV && match |=> oe_q && ackd_q)
    else $error("no acknowledge after matching address");
  chk_no_match_idle: assert property (byte_end && st_q == sems_pkg::ST_DEV && !match |=> !oe_q)
    else $error("acknowledge without address match");
  chk_busy_quiet: assert property (busy_st |-> !oe_q)
    else $error("data line pulled while programming");
  chk_stop_programs: assert property (commit |=> busy_st)
    else $error("stop after write did not start programming");
  chk_prog_single: assert property (commit && !span |=> tmr_q == T_ONE)
    else $error("programming time wrong");
  chk_prog_double: assert property (commit && span |=> tmr_q == T_TWO)
    else $error("doubled programming time wrong");
  chk_filter_hold: assert property ($changed(filt_q[0]) |->
    $past(pin_s2_q[0], 1) == filt_q[0] && $past(pin_s2_q[0], 2) == filt_q[0]
    && $past(pin_s2_q[0], 3) == filt_q[0] && $past(pin_s2_q[0], 4) == filt_q[0])
    else $error("short pulse passed the filter");
  chk_page_wrap: assert property (store && pm_q |=> addr_q[8:3] == $past(addr_q[8:3]))
    else $error("page write changed row bits");
  chk_multi_limit: assert property (!pm_q |-> wcnt_q <= 4'h4)
    else $error("multibyte took more than four bytes");
  chk_read_advance: assert property (slot_end && st_q == sems_pkg::ST_READ && go_on
    |=> addr_q == $past(addr_q) + 9'h1)
    else $error("read address did not advance");
endmodule // sems_slave

// file: tb/sems_master.sv
// two-wire bus master model driving serial clock and data
`timescale 1ns/100ps
module sems_master (
  input wire logic lclk, // link timing base
  input wire logic sda_w, // resolved data wire
  output logic scl_clk, // serial clock, idle high
  output logic sda_drv // data drive, 1 releases
);
  localparam int Q = 10;
  initial begin
    scl_clk = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  task automatic start();
    sda_drv = 1'h1;
    tick(Q);
    scl_clk = 1'h1;
    tick(Q);
    sda_drv = 1'h0;
    tick(Q);
    scl_clk = 1'h0;
    tick(Q);
  endtask
  task automatic stop();
    sda_drv = 1'h0;
    tick(Q);
    scl_clk = 1'h1;
    tick(Q);
    sda_drv = 1'h1;
    tick(Q);
  endtask
  // data moves a quarter after the fall, so the filtered view never sees it beside scl high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(Q);
    scl_clk = 1'h1;
    tick(Q);
    r = sda_w;
    tick(Q);
    scl_clk = 1'h0;
    tick(Q);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask
  // data pulse shorter than the filter window
  task automatic glitch();
    sda_drv = 1'h0;
    tick(3);
    sda_drv = 1'h1;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      b[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule // sems_master

// file: tb/sems_slave_tb_top.sv
// testbench for the two-wire serial memory slave
`timescale 1ns/100ps
module sems_slave_tb_top;
  localparam int P = 50;
  typedef struct {logic p; logic [8:0] a; logic [7:0] d; logic [7:0] e;} sems_row_t;
  logic clk, rstn, lclk, scl_clk, sda_drv, sda_o, sda_oe, busy, cs_h, cs_l, prot, mode, ack;
  logic [7:0] rd;
  int num_errors = 0;
  int compares = 0;
  int cur = 0;
  int last_run = 0;
  // pull-up: the wire is high unless someone pulls it low
  wire sda_w = sda_drv & ~(sda_oe & ~sda_o);
  sems_row_t rows[5] = '{'{1'h0, 9'h005, 8'hA5, 8'hA5}, '{1'h0, 9'h1FF, 8'h3C, 8'h3C},
    '{1'h1, 9'h1FF, 8'h77, 8'h3C}, '{1'h1, 9'h0FF, 8'h5A, 8'h5A}, '{1'h0, 9'h100, 8'hC3, 8'hC3}};
  sems_slave #(.PROG_CYCLES(P)) dut_u (.clk(clk), .rstn(rstn), .scl_clk(scl_clk), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_bit_high(cs_h), .chip_select_bit_low(cs_l),
    .protect_key_input(prot), .wr_mode_sel(mode), .busy(busy));
  sems_master m_u (.lclk(lclk), .sda_w(sda_w), .scl_clk(scl_clk), .sda_drv(sda_drv));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'h0;
    #7;
    forever #16 lclk = ~lclk;
  end
  always @(negedge clk) begin
    if (busy === 1'h1) begin
      cur = cur + 1;
    end else if (cur != 0) begin
      last_run = cur;
      cur = 0;
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic addr_ph(input logic [8:0] a, output logic ok);
    logic k;
    m_u.start();
    m_u.wr_byte({sems_pkg::DEV_TYPE, cs_h, cs_l, a[8], 1'h0}, ok);
    m_u.wr_byte(a[7:0], k);
    ok = ok & k;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d[$], input int n_ack);
    logic k;
    addr_ph(a, k);
    chk(k, 1);
    foreach (d[i]) begin
      m_u.wr_byte(d[i], k);
      chk(k, i < n_ack);
    end
    m_u.stop();
  endtask
  task automatic rd_seq(input logic [8:0] a, input logic rnd, input logic [7:0] exp[$]);
    logic k;
    if (rnd) begin
      addr_ph(a, k);
    end
    m_u.start();
    m_u.wr_byte({sems_pkg::DEV_TYPE, cs_h, cs_l, a[8], 1'h1}, k);
    chk(k, 1);
    foreach (exp[i]) begin
      m_u.rd_byte(i < exp.size() - 1, rd);
      chk(rd, exp[i]);
    end
    m_u.stop();
  endtask
  // bounded wait for the programming cycle to end
  task automatic idle();
    repeat (4) @(negedge clk);
    for (int i = 0; i < 3 * P && busy !== 1'h0; i++) @(negedge clk);
    // one more edge so the run counter has settled before anyone reads it
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    rstn = 1'h0;
    cs_h = 1'h1;
    cs_l = 1'h0;
    prot = 1'h0;
    mode = 1'h1;
    repeat (10) @(negedge clk);
    chk({sda_oe, busy}, 0);
    rstn = 1'h1;
    repeat (10) @(negedge clk);
    foreach (rows[i]) begin
      @(negedge clk);
      prot = rows[i].p;
      wr(rows[i].a, '{rows[i].d}, 1);
      idle();
      rd_seq(rows[i].a, 1'h1, '{rows[i].e});
    end
    m_u.glitch();
    @(negedge clk);
    prot = 1'h0;
    for (int j = 0; j < 4; j++) begin
      m_u.start();
      m_u.wr_byte({sems_pkg::DEV_TYPE, 2'(j), 2'h0}, ack);
      m_u.stop();
      chk(ack, j == 2);
    end
    wr(9'h040, '{8'h11}, 1);
    chk(busy, 1);
    m_u.start();
    m_u.wr_byte({sems_pkg::DEV_TYPE, cs_h, cs_l, 2'h0}, ack);
    m_u.stop();
    chk(ack, 0);
    idle();
    chk(last_run <= P + 1 && last_run > 0, 1);
    wr(9'h00E, '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25}, 4);
    idle();
    chk(last_run > P && last_run <= 2 * P + 2, 1);
    rd_seq(9'h00E, 1'h1, '{8'h21});
    rd_seq(9'h00F, 1'h0, '{8'h22, 8'h23, 8'h24});
    chk(sda_o, 0);
    @(negedge clk);
    mode = 1'h0;
    // nine bytes into one row from slot 3: the ninth lands on the first byte's slot 3 again
    wr(9'h023, '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48}, 9);
    idle();
    chk(last_run <= P + 1, 1);
    rd_seq(9'h020, 1'h1, '{8'h45, 8'h46, 8'h47, 8'h48, 8'h41, 8'h42, 8'h43, 8'h44});
    summarize();
  end
endmodule // sems_slave_tb_top
